// ---- rtdec_map.svh ----
// Opcodes, register offsets and reset values of the transfer decoder
`ifndef RTDEC_MAP_SVH
`define RTDEC_MAP_SVH
`define RTDEC_OP_TIMER_PAIR 10'h01A
`define RTDEC_OP_PSC0 10'h228
`define RTDEC_OP_PSC1 10'h229
`define RTDEC_OP_IRQ1 10'h217
`define RTDEC_OP_IRQ2 10'h218
`define RTDEC_OP_WAKE0 10'h21B
`define RTDEC_OP_WAKE1 10'h214
`define RTDEC_OP_WAKE2 10'h215
`define RTDEC_SEL_TIMER 0
`define RTDEC_NUM_SEL 8
`define RTDEC_NUM_NIB 7
`define RTDEC_TIMER_HI_POS 4
`define RTDEC_ADDR_CTRL 8'h00
`define RTDEC_ADDR_STATUS 8'h04
`define RTDEC_ADDR_TIMER 8'h08
`define RTDEC_ADDR_NIB_BASE 8'h0C
`define RTDEC_CTRL_EN_POS 0
`define RTDEC_CTRL_RST 1'h1
`define RTDEC_NIB_RST 4'h0
`define RTDEC_TIMER_RST 8'h00
`endif

// ---- rtdec_pkg.sv ----
// Types shared by the transfer decoder modules
package rtdec_pkg;
   typedef logic [3:0] rtdec_nib_t;
   typedef logic [7:0] rtdec_byte_t;
   typedef logic [9:0] rtdec_code_t;
   typedef logic [7:0] rtdec_sel_t;
endpackage : rtdec_pkg

// ---- rtdec_sel_if.sv ----
// Carrier between the core and its opcode decoder
interface rtdec_sel_if;
   rtdec_pkg::rtdec_code_t instr;
   logic valid;
   logic enable;
   rtdec_pkg::rtdec_sel_t sel;
   modport dec (input instr, input valid, input enable, output sel);
   modport core (output instr, output valid, output enable, input sel);
endinterface : rtdec_sel_if

// ---- rtdec_decode.sv ----
// Opcode match logic: one select line per transfer target
`include "rtdec_map.svh"
module rtdec_decode (
   input wire logic clk_sys,  // System clock
   input wire logic rst,      // Synchronous reset
   rtdec_sel_if.dec bus       // Instruction in, selects out
);
   localparam rtdec_pkg::rtdec_code_t OPC [0:`RTDEC_NUM_SEL-1] = '{
      `RTDEC_OP_TIMER_PAIR, `RTDEC_OP_PSC0, `RTDEC_OP_PSC1,
      `RTDEC_OP_IRQ1, `RTDEC_OP_IRQ2,
      `RTDEC_OP_WAKE0, `RTDEC_OP_WAKE1, `RTDEC_OP_WAKE2};

   // Full 10-bit compare, so no other instruction aliases a target
   genvar i;
   generate
      for (i = 0; i < `RTDEC_NUM_SEL; i++) begin : g_match
         assign bus.sel[i] = bus.valid && bus.enable &&
                             (bus.instr == OPC[i]);
      end
   endgenerate

   // Distinct codes can never raise two targets at once
   chk_sel_onehot: assert property (@(posedge clk_sys) disable iff (rst)
      $onehot0(bus.sel))
      else $error("two transfer targets selected");
endmodule // rtdec_decode

// ---- rtdec_core.sv ----
// Register transfer decode and execute, with software register port
`include "rtdec_map.svh"
// Overview of operation
// - Code 01A loads the timer data register from aux and accumulator.
// - The paired load puts the aux register in timer bits 7 to 4.
// - The paired load puts the accumulator in timer bits 3 to 0 at once.
// - Codes 228 and 229 copy the accumulator to port structure 0 and 1.
// - Code 217 copies the accumulator to interrupt control 1.
// - Code 218 copies the accumulator to interrupt control 2.
// - Code 214 copies the accumulator to wakeup control 1.
// - Code 215 copies the accumulator to wakeup control 2.
module rtdec_core (
   input wire logic clk_sys,                    // 200 MHz clock
   input wire logic rst,                        // Sync reset, high
   input wire rtdec_pkg::rtdec_code_t instr,    // Instruction word
   input wire logic instr_valid,                // One per instr cycle
   input wire rtdec_pkg::rtdec_nib_t acc,       // Accumulator
   input wire rtdec_pkg::rtdec_nib_t aux,       // Auxiliary register
   input wire logic [7:0] reg_addr,             // Software address
   input wire logic [31:0] reg_wdata,           // Software write data
   input wire logic reg_wr,                     // Write strobe
   input wire logic reg_rd,                     // Read strobe
   output logic [31:0] reg_rdata,               // Read data, next cycle
   output rtdec_pkg::rtdec_byte_t timer_data,   // Timer data register
   output rtdec_pkg::rtdec_nib_t port_struct_ctl0, // Port structure 0
   output rtdec_pkg::rtdec_nib_t port_struct_ctl1, // Port structure 1
   output rtdec_pkg::rtdec_nib_t irq_ctl1,      // Interrupt control 1
   output rtdec_pkg::rtdec_nib_t irq_ctl2,      // Interrupt control 2
   output rtdec_pkg::rtdec_nib_t wake_ctl0,     // Wakeup control 0
   output rtdec_pkg::rtdec_nib_t wake_ctl1,     // Wakeup control 1
   output rtdec_pkg::rtdec_nib_t wake_ctl2,     // Wakeup control 2
   output logic op_done,                        // Transfer executed
   output logic carry_we,                       // Carry write request
   output logic skip_req                        // Skip next instr
);
   rtdec_sel_if sel_bus ();
   rtdec_pkg::rtdec_nib_t nib [0:`RTDEC_NUM_NIB-1];
   logic dec_en;
   logic [7:0] done_cnt;
   logic [2:0] last_tgt;
   logic any_sel;
   logic [2:0] next_tgt;

   assign sel_bus.instr = instr;
   assign sel_bus.valid = instr_valid;
   assign sel_bus.enable = dec_en;
   assign any_sel = |sel_bus.sel;

   rtdec_decode u_decode (
      .clk_sys (clk_sys),
      .rst     (rst),
      .bus     (sel_bus)
   );

   // Target index for the status register
   always_comb begin
      next_tgt = 3'h0;
      for (int k = 0; k < `RTDEC_NUM_SEL; k++) begin
         if (sel_bus.sel[k]) begin
            next_tgt = 3'(k);
         end
      end
   end

   // Paired load: both nibbles land on the same edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer_data <= `RTDEC_TIMER_RST;
      end else if (sel_bus.sel[`RTDEC_SEL_TIMER]) begin
         timer_data[7:`RTDEC_TIMER_HI_POS] <= aux;
         timer_data[`RTDEC_TIMER_HI_POS-1:0] <= acc;
      end
   end

   // Nibble targets: select k+1 loads the whole accumulator into nib k
   genvar n;
   generate
      for (n = 0; n < `RTDEC_NUM_NIB; n++) begin : g_nib
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               nib[n] <= `RTDEC_NIB_RST;
            end else if (sel_bus.sel[n+1]) begin
               nib[n] <= acc;
            end
         end
      end
   endgenerate

   assign port_struct_ctl0 = nib[0];
   assign port_struct_ctl1 = nib[1];
   assign irq_ctl1 = nib[2];
   assign irq_ctl2 = nib[3];
   assign wake_ctl0 = nib[4];
   assign wake_ctl1 = nib[5];
   assign wake_ctl2 = nib[6];

   // Completion in the one cycle; carry and skip are never requested
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         op_done <= 1'b0;
         carry_we <= 1'b0;
         skip_req <= 1'b0;
      end else begin
         op_done <= any_sel;
         carry_we <= 1'b0;
         skip_req <= 1'b0;
      end
   end

   // Status: executed-transfer count and last target
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         done_cnt <= 8'h00;
         last_tgt <= 3'h0;
      end else if (any_sel) begin
         done_cnt <= done_cnt + 8'h01;  // Wraps; a trace aid only
         last_tgt <= next_tgt;
      end
   end

   // Control register; disabling turns every code into a no-op here
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dec_en <= `RTDEC_CTRL_RST;
      end else if (reg_wr && reg_addr == `RTDEC_ADDR_CTRL) begin
         dec_en <= reg_wdata[`RTDEC_CTRL_EN_POS];
      end
   end

   // Read port; targets are read only, unmapped reads return zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h0000_0000;
         case (reg_addr)
            `RTDEC_ADDR_CTRL: reg_rdata[`RTDEC_CTRL_EN_POS] <= dec_en;
            `RTDEC_ADDR_STATUS: reg_rdata[10:0] <= {last_tgt, done_cnt};
            `RTDEC_ADDR_TIMER: reg_rdata[7:0] <= timer_data;
            default: begin
               for (int k = 0; k < `RTDEC_NUM_NIB; k++) begin
                  if (reg_addr == `RTDEC_ADDR_NIB_BASE + 8'(4 * k)) begin
                     reg_rdata[3:0] <= nib[k];
                  end
               end
            end
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // Checks tie each target to its opcode and the sampled sources
   chk_pair_whole: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_TIMER_PAIR) |=>
      timer_data == {$past(aux), $past(acc)})
      else $error("paired timer load wrong");

   chk_pair_upper: assert property (
      @(posedge clk_sys) disable iff (rst)
      sel_bus.sel[`RTDEC_SEL_TIMER] |=>
      timer_data[7:4] == $past(aux))
      else $error("timer upper nibble not from aux");

   chk_pair_lower: assert property (
      @(posedge clk_sys) disable iff (rst)
      sel_bus.sel[`RTDEC_SEL_TIMER] |=>
      timer_data[3:0] == $past(acc))
      else $error("timer lower nibble not from acc");

   chk_port_struct: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_PSC0) |=>
      port_struct_ctl0 == $past(acc) && $stable(port_struct_ctl1))
      else $error("port structure 0 load wrong");

   chk_port_struct1: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_PSC1) |=>
      port_struct_ctl1 == $past(acc) && $stable(port_struct_ctl0))
      else $error("port structure 1 load wrong");

   chk_irq_one: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_IRQ1) |=>
      irq_ctl1 == $past(acc) && $stable(irq_ctl2))
      else $error("interrupt control 1 load wrong");

   chk_irq_two: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_IRQ2) |=>
      irq_ctl2 == $past(acc) && $stable(irq_ctl1))
      else $error("interrupt control 2 load wrong");

   chk_wake_zero: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_WAKE0) |=>
      wake_ctl0 == $past(acc) && $stable(wake_ctl1))
      else $error("wakeup control 0 load wrong");

   chk_wake_one: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_WAKE1) |=>
      wake_ctl1 == $past(acc) && $stable(wake_ctl2))
      else $error("wakeup control 1 load wrong");

   chk_wake_two: assert property (
      @(posedge clk_sys) disable iff (rst)
      (instr_valid && dec_en && instr == `RTDEC_OP_WAKE2) |=>
      wake_ctl2 == $past(acc) && $stable(wake_ctl1))
      else $error("wakeup control 2 load wrong");

   // Done pulse lasts one cycle unless another transfer follows at once
   chk_single_cycle: assert property (
      @(posedge clk_sys) disable iff (rst)
      any_sel |=> op_done ##1 (!op_done || $past(any_sel)))
      else $error("transfer not done in one cycle");

   chk_no_skip_carry: assert property (
      @(posedge clk_sys) disable iff (rst)
      op_done |-> !skip_req && !carry_we)
      else $error("transfer touched carry or skip");
endmodule // rtdec_core

// ---- rtdec_tb.sv ----
// Self-checking bench for the register transfer decoder core
module rtdec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [9:0] code; logic [3:0] a; logic [3:0] b; int idx;}
      rtdec_row_t;
   localparam int NROW = 12;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   rtdec_pkg::rtdec_code_t instr = '0;
   logic instr_valid = 1'b0;
   rtdec_pkg::rtdec_nib_t acc = '0;
   rtdec_pkg::rtdec_nib_t aux = '0;
   logic [7:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   rtdec_pkg::rtdec_byte_t timer_data;
   rtdec_pkg::rtdec_nib_t psc0, psc1, irq1, irq2, wk0, wk1, wk2;
   logic op_done, carry_we, skip_req;
   logic [31:0] got [8];
   logic [31:0] exp_reg [8];
   int fail_count = 0;
   int checks = 0;
   int cnt = 0;
   int last = 0;
   // Index 8 marks a code that must be ignored; neighbours of real codes
   rtdec_row_t rows [NROW] = '{'{10'h01A, 4'h5, 4'hA, 0},
      '{10'h228, 4'hF, 4'h0, 1}, '{10'h229, 4'h3, 4'hC, 2},
      '{10'h217, 4'h9, 4'h6, 3}, '{10'h218, 4'h6, 4'h9, 4},
      '{10'h21B, 4'hC, 4'h3, 5}, '{10'h214, 4'h1, 4'hE, 6},
      '{10'h215, 4'hE, 4'h1, 7}, '{10'h219, 4'h7, 4'h7, 8},
      '{10'h01A, 4'h0, 4'hF, 0}, '{10'h01B, 4'h4, 4'h4, 8},
      '{10'h215, 4'h0, 4'h0, 7}};

   rtdec_core dut (.clk_sys(clk_sys), .rst(rst), .instr(instr),
      .instr_valid(instr_valid), .acc(acc), .aux(aux), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_data(timer_data),
      .port_struct_ctl0(psc0), .port_struct_ctl1(psc1), .irq_ctl1(irq1),
      .irq_ctl2(irq2), .wake_ctl0(wk0), .wake_ctl1(wk1), .wake_ctl2(wk2),
      .op_done(op_done), .carry_we(carry_we), .skip_req(skip_req));

   // Targets gathered in decoder index order for table compares
   assign got = '{32'(timer_data), 32'(psc0), 32'(psc1), 32'(irq1),
      32'(irq2), 32'(wk0), 32'(wk1), 32'(wk2)};

   // 200 MHz system clock
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(logic [31:0] g, logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Expected model: pair load builds the byte, others copy the nibble
   task automatic apply(rtdec_row_t r);
      if (r.idx == 0) exp_reg[0] = {24'h0000_00, r.b, r.a};
      else if (r.idx < 8) exp_reg[r.idx] = {28'h000_0000, r.a};
      if (r.idx < 8) begin
         cnt++;
         last = r.idx;
      end
   endtask

   task automatic check_regs(logic done);
      chk(got[0], exp_reg[0]);
      for (int i = 1; i < 5; i++) begin
         chk(got[i], exp_reg[i]);
      end
      for (int i = 5; i < 8; i++) begin
         chk(got[i], exp_reg[i]);
      end
      chk({31'h0, op_done}, {31'h0, done});
      chk({30'h0, carry_we, skip_req}, 32'h0000_0000);
   endtask

   task automatic issue(logic [9:0] c, logic [3:0] a, logic [3:0] b);
      @(posedge clk_sys);
      instr <= c;
      acc <= a;
      aux <= b;
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
      // Read data stand for one cycle only, then fall back to zero
      @(posedge clk_sys);
      #1;
      chk(reg_rdata, 32'h0000_0000);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Hang guard: every wait in the bench is bounded by this count
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      end_of_test();
   end

   initial begin
      foreach (exp_reg[i]) exp_reg[i] = '0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      // Back-to-back table: row i is driven as row i-1 shows its result
      for (int i = 0; i <= NROW; i++) begin
         @(posedge clk_sys);
         if (i < NROW) begin
            instr <= rows[i].code;
            acc <= rows[i].a;
            aux <= rows[i].b;
            instr_valid <= 1'b1;
         end else instr_valid <= 1'b0;
         #1;
         if (i > 0) begin
            apply(rows[i - 1]);
            check_regs(rows[i - 1].idx < 8);
         end
      end
      $display("test table done");
      for (int i = 0; i < 8; i++) rd(8'h08 + 8'(4 * i), exp_reg[i]);
      rd(8'h04, {21'h0, 3'(last), 8'(cnt)});
      rd(8'h30, 32'h0000_0000);
      $display("test register reads done");
      // Decode disabled: a valid pair load must leave everything alone
      wr(8'h00, 32'h0000_0000);
      rd(8'h00, 32'h0000_0000);
      issue(10'h01A, 4'h1, 4'h2);
      check_regs(1'b0);
      wr(8'h00, 32'h0000_0001);
      issue(10'h21B, 4'hD, 4'h2);
      exp_reg[5] = 32'h0000_000D;
      check_regs(1'b1);
      // Targets are read only: a write to the timer address is ignored
      wr(8'h08, 32'h0000_00FF);
      #1;
      check_regs(1'b0);
      $display("test enable done");
      // Reset in mid-run clears every target
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      foreach (exp_reg[i]) exp_reg[i] = '0;
      check_regs(1'b0);
      rd(8'h00, 32'h0000_0001);
      $display("test reset done");
      end_of_test();
   end
endmodule // rtdec_tb
